// *** adcsc_consts.svh ***
// Register offsets, field positions, reset values and timing counts for the converter control
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH

// Byte offsets on the register bus
`define ADCSC_OFF_SETUP 8'h00
`define ADCSC_OFF_CTL 8'h04
`define ADCSC_OFF_SLOT1 8'h08
`define ADCSC_OFF_SLOT2 8'h0C
`define ADCSC_OFF_SLOT3 8'h10
`define ADCSC_OFF_SLOT4 8'h14

// System setup fields
`define ADCSC_SETUP_PU_BIT 7
`define ADCSC_SETUP_CLOCK_SOURCE_SELECT_BIT 6
`define ADCSC_SETUP_DLY_BIT 4
`define ADCSC_SETUP_ZERO_BIT 2
`define ADCSC_SETUP_MASK 8'hFB
`define ADCSC_SETUP_RESET 8'h00

// Control/status fields
`define ADCSC_CTL_CCF_BIT 7
`define ADCSC_CTL_ZERO_BIT 6
`define ADCSC_CTL_RESET 6'h00

// Timing, in bus clock cycles or converter steps
`define ADCSC_STOP_DLY_CYC 12'd4000
`define ADCSC_STOP_FAST_CYC 12'd4
`define ADCSC_STEP_DIV 2'd3
`define ADCSC_SAMPLE_STEPS 4'd12
`define ADCSC_LAST_IDX 2'd3

`endif

// *** adcsc_pkg.sv ***
// Types shared by the converter sequencer and its approximation engine
package adcsc_pkg;

  typedef enum {SEQ_IDLE, SEQ_RUN, SEQ_SUSP, SEQ_EXIT} adcsc_seq_t;
  typedef enum {SAR_IDLE, SAR_SAMPLE, SAR_COMPARE} adcsc_sar_st_t;

  typedef struct packed {
    logic scan;
    logic group_conversion_select;
    logic [3:0] sel;
  } adcsc_ctl_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic sample;
    logic [7:0] trial;
    logic [7:0] result;
  } adcsc_sar_out_t;

  // Multiplexer code for conversion idx of a sequence
  function automatic logic [3:0] adcsc_chan(input adcsc_ctl_t ctl, input logic [1:0] idx);
    adcsc_chan = ctl.group_conversion_select ? {ctl.sel[3:2], idx} : ctl.sel;
  endfunction : adcsc_chan

endpackage : adcsc_pkg

// *** adcsc_sar.sv ***
// Successive approximation engine: sample phase then eight MSB-first comparisons
`timescale 1ns/100ps
`include "adcsc_consts.svh"
module adcsc_sar import adcsc_pkg::*; (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic comp,
  // State and data
  output adcsc_sar_out_t sar_o
);

  adcsc_sar_st_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] bit_reg;
  logic [7:0] code_reg;
  logic [7:0] result_reg;
  logic done_reg;

  // Drop the trial bit when the input lies below it
  wire [7:0] kept = comp ? code_reg : (code_reg & ~bit_reg);
  wire last_bit = bit_reg[0];
  wire sample_end = (cnt_reg == `ADCSC_SAMPLE_STEPS - 4'd1);

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_reg <= SAR_IDLE;
      cnt_reg <= 4'h0;
      bit_reg <= 8'h00;
      code_reg <= 8'h00;
      result_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (abort) begin
        state_reg <= SAR_IDLE;
      end else if (start) begin
        state_reg <= SAR_SAMPLE;
        cnt_reg <= 4'h0;
        code_reg <= 8'h00;
      end else if (tick) begin
        case (state_reg)
          SAR_SAMPLE: begin
            cnt_reg <= cnt_reg + 4'h1;
            if (sample_end) begin
              state_reg <= SAR_COMPARE;
              bit_reg <= 8'h80;
              code_reg <= 8'h80;
            end
          end
          SAR_COMPARE: begin
            bit_reg <= bit_reg >> 1;
            code_reg <= kept | (bit_reg >> 1);
            if (last_bit) begin
              result_reg <= kept;
              done_reg <= 1'b1;
              state_reg <= SAR_IDLE;
            end
          end
          default: state_reg <= SAR_IDLE;
        endcase
      end
    end
  end

  assign sar_o.busy = (state_reg != SAR_IDLE);
  assign sar_o.done = done_reg;
  assign sar_o.sample = (state_reg == SAR_SAMPLE);
  assign sar_o.trial = code_reg;
  assign sar_o.result = result_reg;

endmodule : adcsc_sar

// *** adcsc_top.sv ***
// Converter sequence control: register bus slave, sequencer, result slots and power modes
`timescale 1ns/100ps
`include "adcsc_consts.svh"
module adcsc_top import adcsc_pkg::*; (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Power mode pins
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  // Analog front end
  input wire logic ANA_COMP,
  input wire logic RC_CLK,
  output logic ANA_POWER_UP,
  output logic [3:0] ANA_CHAN_SEL,
  output logic ANA_SAMPLE,
  output logic [7:0] ANA_DAC_CODE,
  output logic NVM_CLK_SEL
);

  // Synchronisers: stop, wait, comparator, RC clock
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic rc_d_reg;
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
      rc_d_reg <= 1'b0;
    end else begin
      meta_reg <= {RC_CLK, ANA_COMP, WAIT_MODE, STOP_MODE};
      sync_reg <= meta_reg;
      rc_d_reg <= sync_reg[3];
    end
  end
  wire stop_s = sync_reg[0];
  wire wait_s = sync_reg[1];
  wire comp_s = sync_reg[2];
  wire rc_edge = sync_reg[3] & ~rc_d_reg;
  wire susp = stop_s | wait_s;

  // Registers
  logic [7:0] setup_reg;
  adcsc_ctl_t ctl_reg;
  logic ccf_reg;
  logic ccf_next;
  logic [7:0] slot_reg [4];
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic start_pend_reg;
  logic [1:0] div_reg;

  wire pu = setup_reg[`ADCSC_SETUP_PU_BIT];
  wire clock_source_select = setup_reg[`ADCSC_SETUP_CLOCK_SOURCE_SELECT_BIT];
  wire dly = setup_reg[`ADCSC_SETUP_DLY_BIT];

  // Bus decode; a write lands on the acknowledging edge only
  wire wb_req = WB_CYC_I & WB_STB_I;
  wire wr_lane = ack_reg & wb_req & WB_WE_I & WB_SEL_I[0];
  wire wr_setup = wr_lane & (WB_ADR_I == `ADCSC_OFF_SETUP);
  wire wr_ctl = wr_lane & (WB_ADR_I == `ADCSC_OFF_CTL);
  wire [7:0] setup_rd = setup_reg & `ADCSC_SETUP_MASK;
  wire [7:0] ctl_rd = {ccf_reg, 1'b0, ctl_reg};
  logic [7:0] rd_byte;
  always_comb begin
    case (WB_ADR_I)
      `ADCSC_OFF_SETUP: rd_byte = setup_rd;
      `ADCSC_OFF_CTL: rd_byte = ctl_rd;
      `ADCSC_OFF_SLOT1: rd_byte = slot_reg[0];
      `ADCSC_OFF_SLOT2: rd_byte = slot_reg[1];
      `ADCSC_OFF_SLOT3: rd_byte = slot_reg[2];
      `ADCSC_OFF_SLOT4: rd_byte = slot_reg[3];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req & ~ack_reg;
      if (wb_req & ~ack_reg) begin
        rdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;

  // Converter step enable: bus divider or synchronised RC edge
  wire e_tick = (div_reg == `ADCSC_STEP_DIV);
  wire tick = clock_source_select ? rc_edge : e_tick;

  // Sequencer
  adcsc_seq_t seq_reg;
  adcsc_seq_t seq_next;
  logic [1:0] idx_reg;
  logic [1:0] idx_next;
  logic [11:0] dly_reg;
  logic [11:0] dly_next;
  logic was_stop_reg;
  logic was_stop_next;
  logic resume_go;
  adcsc_sar_out_t sar_o;

  wire seq_done = sar_o.done & (seq_reg == SEQ_RUN);
  wire at_last = (idx_reg == `ADCSC_LAST_IDX);
  wire last_done = seq_done & at_last;
  wire seq_halt = last_done & ~ctl_reg.scan;
  wire next_go = seq_done & ~seq_halt & ~susp & ~start_pend_reg;
  wire sar_start = pu & ((start_pend_reg & ~susp) | resume_go | next_go);
  wire sar_abort = ~pu | wr_ctl | (susp & (seq_reg == SEQ_RUN));

  always_comb begin
    seq_next = seq_reg;
    idx_next = idx_reg;
    dly_next = dly_reg;
    was_stop_next = was_stop_reg;
    resume_go = 1'b0;
    if (!pu) begin
      seq_next = SEQ_IDLE;
      idx_next = 2'd0;
    end else if (start_pend_reg) begin
      idx_next = 2'd0;
      seq_next = susp ? SEQ_SUSP : SEQ_RUN;
      was_stop_next = ((seq_reg == SEQ_SUSP) & was_stop_reg) | stop_s;
    end else begin
      case (seq_reg)
        SEQ_RUN: begin
          if (seq_done) begin
            idx_next = idx_reg + 2'd1;
          end
          if (seq_halt) begin
            seq_next = SEQ_IDLE;
          end else if (susp) begin
            seq_next = SEQ_SUSP;
            was_stop_next = stop_s;
          end
        end
        SEQ_SUSP: begin
          was_stop_next = was_stop_reg | stop_s;
          if (!susp && was_stop_reg) begin
            seq_next = SEQ_EXIT;
            dly_next = (dly ? `ADCSC_STOP_DLY_CYC : `ADCSC_STOP_FAST_CYC) - 12'd1;
          end else if (!susp) begin
            seq_next = SEQ_RUN;
            resume_go = 1'b1;
          end
        end
        SEQ_EXIT: begin
          if (susp) begin
            seq_next = SEQ_SUSP;
          end else if (dly_reg == 12'd0) begin
            seq_next = SEQ_RUN;
            resume_go = 1'b1;
            was_stop_next = 1'b0;
          end else begin
            dly_next = dly_reg - 12'd1;
          end
        end
        default: seq_next = SEQ_IDLE;
      endcase
    end
  end

  // Hardware set wins over the clearing write
  assign ccf_next = last_done | (ccf_reg & ~wr_ctl);

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      setup_reg <= `ADCSC_SETUP_RESET;
      ctl_reg <= `ADCSC_CTL_RESET;
      ccf_reg <= 1'b0;
      start_pend_reg <= 1'b0;
      div_reg <= 2'd0;
      seq_reg <= SEQ_IDLE;
      idx_reg <= 2'd0;
      dly_reg <= 12'd0;
      was_stop_reg <= 1'b0;
    end else begin
      if (wr_setup) begin
        setup_reg <= WB_DAT_I[7:0] & `ADCSC_SETUP_MASK;
      end
      if (wr_ctl) begin
        ctl_reg <= WB_DAT_I[5:0];
      end
      ccf_reg <= ccf_next;
      start_pend_reg <= wr_ctl;
      div_reg <= e_tick ? 2'd0 : div_reg + 2'd1;
      seq_reg <= seq_next;
      idx_reg <= idx_next;
      dly_reg <= dly_next;
      was_stop_reg <= was_stop_next;
    end
  end

  // Result slots; no reset because contents are undefined until a conversion lands
  always_ff @(posedge MCLK) begin
    if (seq_done) begin
      slot_reg[idx_reg] <= sar_o.result;
    end
  end

  adcsc_sar u_sar (
    .MCLK(MCLK),
    .SYS_RST(SYS_RST),
    .start(sar_start),
    .abort(sar_abort),
    .tick(tick),
    .comp(comp_s),
    .sar_o(sar_o)
  );

  // Reserved selections are still driven; the front end decides what they see
  assign ANA_CHAN_SEL = adcsc_chan(ctl_reg, idx_reg);
  assign ANA_POWER_UP = pu;
  assign ANA_SAMPLE = sar_o.sample;
  assign ANA_DAC_CODE = sar_o.trial;
  assign NVM_CLK_SEL = clock_source_select;

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  property p_start_after_write;
    wr_ctl && pu && !susp |=> sar_start;
  endproperty
  a_start_after_write: assert property (p_start_after_write) else $error("no start after control write");

  property p_ccf_clear;
    wr_ctl && !last_done |=> !ccf_reg;
  endproperty
  a_ccf_clear: assert property (p_ccf_clear) else $error("flag not cleared by write");

  property p_ccf_set;
    last_done |=> ccf_reg;
  endproperty
  a_ccf_set: assert property (p_ccf_set) else $error("flag not set after fourth result");

  property p_setup_zero;
    ack_reg && !WB_WE_I && WB_ADR_I == `ADCSC_OFF_SETUP |-> !WB_DAT_O[`ADCSC_SETUP_ZERO_BIT];
  endproperty
  a_setup_zero: assert property (p_setup_zero) else $error("setup bit 2 reads one");

  property p_ctl_zero;
    ack_reg && !WB_WE_I && WB_ADR_I == `ADCSC_OFF_CTL |-> !WB_DAT_O[`ADCSC_CTL_ZERO_BIT];
  endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("control bit 6 reads one");

  property p_power_down;
    !pu |=> !sar_o.busy && seq_reg == SEQ_IDLE;
  endproperty
  a_power_down: assert property (p_power_down) else $error("converter active while powered down");

  property p_group_chan;
    seq_reg == SEQ_RUN && ctl_reg.group_conversion_select |-> ANA_CHAN_SEL == {ctl_reg.sel[3:2], idx_reg};
  endproperty
  a_group_chan: assert property (p_group_chan) else $error("wrong group channel");

  property p_single_chan;
    seq_reg == SEQ_RUN && !ctl_reg.group_conversion_select |-> ANA_CHAN_SEL == ctl_reg.sel;
  endproperty
  a_single_chan: assert property (p_single_chan) else $error("wrong single channel");

  property p_halt;
    seq_halt && !start_pend_reg && !wr_ctl && pu |=> seq_reg == SEQ_IDLE ##1 !sar_o.busy;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt after single sequence");

  property p_exit_delay;
    seq_reg == SEQ_SUSP && !susp && was_stop_reg && dly && pu && !start_pend_reg
      |=> seq_reg == SEQ_EXIT && dly_reg == `ADCSC_STOP_DLY_CYC - 12'd1;
  endproperty
  a_exit_delay: assert property (p_exit_delay) else $error("stop exit delay not loaded");

  property p_slot_store;
    seq_done |=> slot_reg[$past(idx_reg)] == $past(sar_o.result);
  endproperty
  a_slot_store: assert property (p_slot_store) else $error("result not stored in slot");

  property p_resume;
    seq_reg == SEQ_SUSP && !susp && !was_stop_reg && pu && !start_pend_reg |=> sar_o.sample;
  endproperty
  a_resume: assert property (p_resume) else $error("no resample on resume");

  property p_fast_exit;
    seq_reg == SEQ_SUSP && !susp && was_stop_reg && !dly && pu && !start_pend_reg
      |=> seq_reg == SEQ_EXIT && dly_reg == `ADCSC_STOP_FAST_CYC - 12'd1;
  endproperty
  a_fast_exit: assert property (p_fast_exit) else $error("short stop exit delay not loaded");

  property p_idx_step;
    seq_done && !at_last && pu && !start_pend_reg |=> idx_reg == $past(idx_reg) + 2'd1;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("slot index did not advance");

  property p_wrap;
    last_done && ctl_reg.scan && pu && !start_pend_reg |=> idx_reg == 2'd0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("slot index did not wrap to slot one");

  property p_ccf_hold;
    ccf_reg && !wr_ctl |=> ccf_reg;
  endproperty
  a_ccf_hold: assert property (p_ccf_hold) else $error("flag dropped without control write");

  c_scan_wrap: cover property (last_done && ctl_reg.scan ##1 sar_o.busy);
  c_group_done: cover property (last_done && ctl_reg.group_conversion_select && !ctl_reg.scan);
  c_stop_exit: cover property (seq_reg == SEQ_EXIT ##1 seq_reg == SEQ_RUN);
  c_abort: cover property (wr_ctl && sar_o.busy);
  c_fast_exit: cover property (seq_reg == SEQ_EXIT && !dly ##1 seq_reg == SEQ_RUN);

endmodule : adcsc_top

// *** adc_sequence_control_bench.sv ***
// Self-checking bench for the converter sequence control
`timescale 1ns/100ps
`include "adcsc_consts.svh"
module adc_sequence_control_bench;
  import adcsc_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack;
  logic stop_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic [2:0] rc_cnt = 3'h0;
  logic power_up;
  logic [3:0] chan;
  logic sample;
  logic [7:0] dac;
  logic nvm_sel;
  logic [7:0] shift = 8'h00;
  logic [7:0] rd;
  int mismatches = 0;
  int total_checks = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) rc_cnt <= rc_cnt + 3'h1;

  // Analog input level seen on each multiplexer code
  function automatic logic [7:0] tgt(input logic [3:0] c);
    tgt = (c == 4'hC) ? 8'hFF : (c == 4'hD) ? 8'h00 : ({c, ~c} ^ shift);
  endfunction : tgt

  adcsc_top u_dut (
    .MCLK(mclk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .STOP_MODE(stop_mode), .WAIT_MODE(wait_mode), .ANA_COMP(tgt(chan) >= dac),
    .RC_CLK(rc_cnt[2]), .ANA_POWER_UP(power_up), .ANA_CHAN_SEL(chan), .ANA_SAMPLE(sample),
    .ANA_DAC_CODE(dac), .NVM_CLK_SEL(nvm_sel)
  );

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Classic single cycle; held until ack is sampled high
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dat <= {24'h00_0000, d};
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask : acc

  task wflag;
    int n;
    n = 0;
    rd = 8'h00;
    while (rd[7] !== 1'b1 && n < 600) begin
      acc(1'b0, `ADCSC_OFF_CTL, 8'h00);
      n++;
    end
    chk("flag", {7'h00, rd[7]}, 8'h01);
  endtask : wflag

  task slots(input logic [3:0] c, input logic grp);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, `ADCSC_OFF_SLOT1 + 8'(4 * i), 8'h00);
      chk("slot", rd, tgt(grp ? {c[3:2], 2'(i)} : c));
    end
  endtask : slots

  task results;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    results();
  end

  initial begin
    int n;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    acc(1'b0, `ADCSC_OFF_SETUP, 8'h00);
    chk("setup reset", rd, 8'h00);
    chk("power pin", {7'h00, power_up}, 8'h00);
    acc(1'b1, `ADCSC_OFF_SETUP, 8'hFF);
    acc(1'b0, `ADCSC_OFF_SETUP, 8'h00);
    chk("setup", rd, 8'hFB);
    chk("clock pin", {6'h00, nvm_sel, power_up}, 8'h03);
    acc(1'b1, `ADCSC_OFF_SETUP, 8'h80);
    repeat (10000) @(posedge mclk);
    acc(1'b1, `ADCSC_OFF_CTL, 8'hFF);
    acc(1'b0, `ADCSC_OFF_CTL, 8'h00);
    chk("control", rd, 8'h3F);
    acc(1'b0, 8'h40, 8'h00);
    chk("unmapped", rd, 8'h00);
    chk("upper bytes", dat_o[31:24] | dat_o[23:16] | dat_o[15:8], 8'h00);
    acc(1'b1, `ADCSC_OFF_CTL, 8'h05);
    n = 0;
    while (sample !== 1'b1 && n < 6) begin
      @(posedge mclk);
      n++;
    end
    chk("start", {7'h00, sample}, 8'h01);
    wflag();
    slots(4'h5, 1'b0);
    acc(1'b1, `ADCSC_OFF_SLOT1, ~tgt(4'h5));
    acc(1'b0, `ADCSC_OFF_SLOT1, 8'h00);
    chk("slot write", rd, tgt(4'h5));
    repeat (200) @(posedge mclk);
    chk("halted", {7'h00, sample}, 8'h00);
    // Low select bits set on purpose: group mode must ignore them
    for (int g = 0; g < 4; g++) begin
      acc(1'b1, `ADCSC_OFF_CTL, {4'h1, 2'(g), 2'b11});
      wflag();
      slots({2'(g), 2'b11}, 1'b1);
    end
    acc(1'b1, `ADCSC_OFF_CTL, 8'h26);
    wflag();
    shift <= 8'h0F;
    repeat (800) @(posedge mclk);
    acc(1'b0, `ADCSC_OFF_CTL, 8'h00);
    chk("scan flag", rd, 8'hA6);
    slots(4'h6, 1'b0);
    acc(1'b1, `ADCSC_OFF_CTL, 8'h37);
    acc(1'b0, `ADCSC_OFF_CTL, 8'h00);
    chk("abort", rd, 8'h37);
    wflag();
    repeat (600) @(posedge mclk);
    slots(4'h7, 1'b1);
    shift <= 8'h00;
    // Stop with the long exit delay
    acc(1'b1, `ADCSC_OFF_SETUP, 8'h90);
    acc(1'b1, `ADCSC_OFF_CTL, 8'h03);
    repeat (100) @(posedge mclk);
    stop_mode <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("suspend", {7'h00, sample}, 8'h00);
    stop_mode <= 1'b0;
    repeat (3900) @(posedge mclk);
    chk("stop delay", {7'h00, sample}, 8'h00);
    n = 0;
    while (sample !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk("resume", {7'h00, sample}, 8'h01);
    wflag();
    slots(4'h3, 1'b0);
    acc(1'b1, `ADCSC_OFF_CTL, 8'h0C);
    repeat (150) @(posedge mclk);
    wait_mode <= 1'b1;
    repeat (30) @(posedge mclk);
    wait_mode <= 1'b0;
    wflag();
    slots(4'hC, 1'b0);
    // Converter steps now come from the RC pin
    acc(1'b1, `ADCSC_OFF_SETUP, 8'hC0);
    acc(1'b1, `ADCSC_OFF_CTL, 8'h0D);
    wflag();
    slots(4'hD, 1'b0);
    // Short stop exit delay comes last: no result is trusted after it
    acc(1'b1, `ADCSC_OFF_SETUP, 8'h80);
    acc(1'b1, `ADCSC_OFF_CTL, 8'h01);
    repeat (100) @(posedge mclk);
    stop_mode <= 1'b1;
    repeat (20) @(posedge mclk);
    stop_mode <= 1'b0;
    n = 0;
    while (sample !== 1'b1 && n < 12) begin
      @(posedge mclk);
      n++;
    end
    chk("fast exit", {7'h00, sample}, 8'h01);
    acc(1'b1, `ADCSC_OFF_SETUP, 8'h00);
    // The write lands on the ack edge; look one edge later
    @(posedge mclk);
    chk("power down", {7'h00, power_up}, 8'h00);
    results();
  end
endmodule : adc_sequence_control_bench
